// file: src/psout_map.svh
// Register offsets, field positions, reset values and timing constants
// for the programmable supervisor outputs. Definitions only.
`ifndef PSOUT_MAP_SVH
`define PSOUT_MAP_SVH

// Register offsets
`define PSOUT_OFS_SEC_MODE 8'h0e
`define PSOUT_OFS_RST_CAUSE 8'h11
`define PSOUT_OFS_RST_CFG 8'h12
`define PSOUT_OFS_FLT_CAUSE 8'h13
`define PSOUT_OFS_FLT_CFG 8'h14
`define PSOUT_OFS_STATUS 8'h30

// Writable bit masks; other bits read as zero
`define PSOUT_MSK_SEC_MODE 8'h3f
`define PSOUT_MSK_RST_CFG 8'h8f
`define PSOUT_MSK_FLT_CFG 8'h0f

// Reset values
`define PSOUT_RST_SEC_MODE 8'h00
`define PSOUT_RST_RST_CAUSE 8'h01
`define PSOUT_RST_RST_CFG 8'h00
`define PSOUT_RST_FLT_CAUSE 8'h02
`define PSOUT_RST_FLT_CFG 8'h00

// Field positions
`define PSOUT_BIT_MR 0
`define PSOUT_BIT_OTHER 1
`define PSOUT_BIT_IN_LO 2
`define PSOUT_BIT_IN_HI 7
`define PSOUT_BIT_OPEN_DRAIN 0
`define PSOUT_BIT_DLY_LO 1
`define PSOUT_BIT_DLY_HI 3
`define PSOUT_BIT_WDO 7

// Clock rate and release delays in microseconds
`define PSOUT_CLK_MHZ 125
`define PSOUT_DLY0_US 25
`define PSOUT_DLY1_US 1560
`define PSOUT_DLY2_US 6250
`define PSOUT_DLY3_US 25000
`define PSOUT_DLY4_US 50000
`define PSOUT_DLY5_US 200000
`define PSOUT_DLY6_US 400000
`define PSOUT_DLY7_US 1600000

`endif

// file: src/psout_pkg.sv
// Types shared by the programmable supervisor outputs.
// Assumes the map header supplies the numeric constants.
package psout_pkg;

  // One output pin: drive low when oe, weak pullup when pull_en
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_en;
  } psout_pin_t;

  // Raw inputs arriving from pins and analog comparators
  typedef struct packed {
    logic manual_reset_in_b;
    logic test_hold_b;
    logic supply_ok;
    logic [5:0] mon_primary_uv;
    logic [5:0] mon_secondary_below;
  } psout_sense_t;

endpackage

// file: src/psout_top.sv
// Reset and supply-fault output logic with programmable causes and
// release delays, plus its configuration register port.
// Assumes a register port driven by the serial interface on clk_sys,
// comparator flags and pins that are asynchronous, and a watchdog
// level from on-chip logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "psout_map.svh"

// Function
// - Both outputs active low, each open-drain or weak pullup.
// - Output with no cause selected stays asserted low forever.
// - Below supply lockout level every output is held low.
// - Reset cause register: manual reset, fault output, primary flags.
// - Reset config bit 7 adds watchdog output as reset cause.
// - Reset releases only when all selected causes inactive.
// - Reset stays low for release delay after causes clear.
// - Reset delay code selects 25us up to 1600ms.
// - Reset config bit 0 picks open-drain or weak pullup.
// - Fault cause register: manual reset, reset output, secondary flags.
// - Fault releases only when all selected causes inactive.
// - Fault stays low for release delay after causes clear.
// - Fault delay code uses the reset delay mapping.
// - Fault config bit 0 picks open-drain or weak pullup.
// - Secondary mode bit picks undervoltage or overvoltage sense.
// - Test hold freezes outputs, over manual reset.
module psout_top
  import psout_pkg::*;
#(
  parameter int unsigned CNT_W = 28,
  parameter int unsigned DELAY_CYC [8] = '{
    `PSOUT_DLY0_US * `PSOUT_CLK_MHZ,
    `PSOUT_DLY1_US * `PSOUT_CLK_MHZ,
    `PSOUT_DLY2_US * `PSOUT_CLK_MHZ,
    `PSOUT_DLY3_US * `PSOUT_CLK_MHZ,
    `PSOUT_DLY4_US * `PSOUT_CLK_MHZ,
    `PSOUT_DLY5_US * `PSOUT_CLK_MHZ,
    `PSOUT_DLY6_US * `PSOUT_CLK_MHZ,
    `PSOUT_DLY7_US * `PSOUT_CLK_MHZ
  }
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,

  // Asynchronous pins and comparator flags
  input wire psout_sense_t sense,

  // Watchdog output level from on-chip logic
  input wire logic watchdog_out_active,

  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,

  // Supervisor output pins
  output psout_pin_t reset_out_pin,
  output psout_pin_t supply_fault_out_pin
);

  // Delay table must fit the counter and never be zero
  for (genvar i = 0; i < 8; i++) begin : g_chk
    if (DELAY_CYC[i] == 0 || DELAY_CYC[i] >= (64'd1 << CNT_W)) begin : g_bad
      $error("psout_top: delay entry out of counter range");
    end
  end
  if (CNT_W < 1 || CNT_W > 31) begin : g_bad_w
    $error("psout_top: counter width unsupported");
  end

  function automatic logic [CNT_W-1:0] delay_cycles(input logic [2:0] code);
    return CNT_W'(DELAY_CYC[code]);
  endfunction

  // Counter reloads while a cause stands and runs down after it clears
  function automatic logic [CNT_W-1:0] cnt_next(
    input logic cause,
    input logic [CNT_W-1:0] cnt,
    input logic [2:0] code
  );
    if (cause) begin
      return delay_cycles(code);
    end
    if (cnt != '0) begin
      return cnt - CNT_W'(1);
    end
    return cnt;
  endfunction

  // Input synchronisers
  psout_sense_t sense_s1_r;
  psout_sense_t sense_s2_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sense_s1_r <= '0;
      sense_s2_r <= '0;
    end else if (clk_en) begin
      sense_s1_r <= sense;
      sense_s2_r <= sense_s1_r;
    end
  end

  // Synchronised view; supply_ok low after reset keeps lockout active
  wire logic mr_low = ~sense_s2_r.manual_reset_in_b;
  wire logic hold = ~sense_s2_r.test_hold_b;
  wire logic lockout = ~sense_s2_r.supply_ok;
  wire logic [5:0] prim_uv = sense_s2_r.mon_primary_uv;
  wire logic [5:0] sec_below = sense_s2_r.mon_secondary_below;

  // Configuration registers
  logic [7:0] sec_mode_r;
  logic [7:0] reset_cause_select_r;
  logic [7:0] reset_output_config_r;
  logic [7:0] fault_output_cause_select_r;
  logic [7:0] fault_output_config_r;

  wire logic wr_sec_mode = reg_wr_en && reg_addr == `PSOUT_OFS_SEC_MODE;
  wire logic wr_rst_cause = reg_wr_en && reg_addr == `PSOUT_OFS_RST_CAUSE;
  wire logic wr_rst_cfg = reg_wr_en && reg_addr == `PSOUT_OFS_RST_CFG;
  wire logic wr_flt_cause = reg_wr_en && reg_addr == `PSOUT_OFS_FLT_CAUSE;
  wire logic wr_flt_cfg = reg_wr_en && reg_addr == `PSOUT_OFS_FLT_CFG;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sec_mode_r <= `PSOUT_RST_SEC_MODE;
      reset_cause_select_r <= `PSOUT_RST_RST_CAUSE;
      reset_output_config_r <= `PSOUT_RST_RST_CFG;
      fault_output_cause_select_r <= `PSOUT_RST_FLT_CAUSE;
      fault_output_config_r <= `PSOUT_RST_FLT_CFG;
    end else if (clk_en) begin
      if (wr_sec_mode) begin
        sec_mode_r <= reg_wdata & `PSOUT_MSK_SEC_MODE;
      end
      if (wr_rst_cause) begin
        reset_cause_select_r <= reg_wdata;
      end
      if (wr_rst_cfg) begin
        reset_output_config_r <= reg_wdata & `PSOUT_MSK_RST_CFG;
      end
      if (wr_flt_cause) begin
        fault_output_cause_select_r <= reg_wdata;
      end
      if (wr_flt_cfg) begin
        fault_output_config_r <= reg_wdata & `PSOUT_MSK_FLT_CFG;
      end
    end
  end

  // Output state
  logic rst_asserted_r;
  logic flt_asserted_r;
  logic [CNT_W-1:0] rst_cnt_r;
  logic [CNT_W-1:0] flt_cnt_r;

  // Read side, including a status view of the output engines
  wire logic [7:0] status_val = {4'h0, hold, lockout, flt_asserted_r, rst_asserted_r};
  wire logic [7:0] rd_mux =
    (reg_addr == `PSOUT_OFS_SEC_MODE) ? sec_mode_r :
    (reg_addr == `PSOUT_OFS_RST_CAUSE) ? reset_cause_select_r :
    (reg_addr == `PSOUT_OFS_RST_CFG) ? reset_output_config_r :
    (reg_addr == `PSOUT_OFS_FLT_CAUSE) ? fault_output_cause_select_r :
    (reg_addr == `PSOUT_OFS_FLT_CFG) ? fault_output_config_r :
    (reg_addr == `PSOUT_OFS_STATUS) ? status_val :
    8'h00;

  logic [7:0] rdata_r;
  logic rvalid_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else if (clk_en) begin
      rvalid_r <= reg_rd_en;
      if (reg_rd_en) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  // Register fields
  wire logic [2:0] rst_code =
    reset_output_config_r[`PSOUT_BIT_DLY_HI:`PSOUT_BIT_DLY_LO];
  // code 110 is the shared 400ms entry
  wire logic [2:0] flt_code =
    fault_output_config_r[`PSOUT_BIT_DLY_HI:`PSOUT_BIT_DLY_LO];
  wire logic rst_wdo_sel = reset_output_config_r[`PSOUT_BIT_WDO];
  wire logic [5:0] rst_in_sel =
    reset_cause_select_r[`PSOUT_BIT_IN_HI:`PSOUT_BIT_IN_LO];
  wire logic [5:0] flt_in_sel =
    fault_output_cause_select_r[`PSOUT_BIT_IN_HI:`PSOUT_BIT_IN_LO];

  // overvoltage mode trips when above the secondary level
  wire logic [5:0] sec_trip = sec_below ^ sec_mode_r[5:0];

  // watchdog term gated by its select
  // The other output is taken from its flop, so the two outputs
  // can depend on each other without a combinational loop.
  wire logic rst_any =
    (reset_cause_select_r[`PSOUT_BIT_MR] & mr_low) |
    (reset_cause_select_r[`PSOUT_BIT_OTHER] & flt_asserted_r) |
    (|(rst_in_sel & prim_uv)) |
    (rst_wdo_sel & watchdog_out_active);

  wire logic rst_none = (reset_cause_select_r == 8'h00) & ~rst_wdo_sel;

  wire logic flt_any =
    (fault_output_cause_select_r[`PSOUT_BIT_MR] & mr_low) |
    (fault_output_cause_select_r[`PSOUT_BIT_OTHER] & rst_asserted_r) |
    (|(flt_in_sel & sec_trip));

  wire logic flt_none = fault_output_cause_select_r == 8'h00;

  // lockout acts as a cause on both outputs
  wire logic rst_cause = lockout | rst_none | rst_any;
  wire logic flt_cause = lockout | flt_none | flt_any;

  // reset stays low while the counter runs down
  wire logic [CNT_W-1:0] rst_cnt_nxt = cnt_next(rst_cause, rst_cnt_r, rst_code);
  wire logic rst_asserted_nxt = rst_cause | (rst_cnt_r != '0);
  // fault stays low while the counter runs down
  wire logic [CNT_W-1:0] flt_cnt_nxt = cnt_next(flt_cause, flt_cnt_r, flt_code);
  wire logic flt_asserted_nxt = flt_cause | (flt_cnt_r != '0);

  // hold freezes engines, lockout still wins
  wire logic freeze = hold & ~lockout;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_asserted_r <= 1'b1;
      flt_asserted_r <= 1'b1;
      rst_cnt_r <= '0;
      flt_cnt_r <= '0;
    end else if (clk_en && !freeze) begin
      rst_asserted_r <= rst_asserted_nxt;
      flt_asserted_r <= flt_asserted_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      flt_cnt_r <= flt_cnt_nxt;
    end
  end

  // Pin drivers
  // drive low when asserted
  // reset pullup only when not open-drain
  wire psout_pin_t rst_pin_nxt = '{
    out: 1'b0,
    oe: rst_asserted_r,
    pull_en: ~rst_asserted_r & ~reset_output_config_r[`PSOUT_BIT_OPEN_DRAIN]
  };
  // fault pullup only when not open-drain
  wire psout_pin_t flt_pin_nxt = '{
    out: 1'b0,
    oe: flt_asserted_r,
    pull_en: ~flt_asserted_r & ~fault_output_config_r[`PSOUT_BIT_OPEN_DRAIN]
  };

  // Pins reset to driven low so the reset line is asserted from power-on
  psout_pin_t rst_pin_r;
  psout_pin_t flt_pin_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_pin_r <= '{out: 1'b0, oe: 1'b1, pull_en: 1'b0};
      flt_pin_r <= '{out: 1'b0, oe: 1'b1, pull_en: 1'b0};
    end else if (clk_en) begin
      rst_pin_r <= rst_pin_nxt;
      flt_pin_r <= flt_pin_nxt;
    end
  end

  assign reset_out_pin = rst_pin_r;
  assign supply_fault_out_pin = flt_pin_r;

endmodule
`default_nettype wire

// file: verif/psout_properties.sv
// Checker for psout_top, bound into every instance of it.
// Assumes registers change only through the register port.
`timescale 1ns/1ps
`default_nettype none
module psout_chk
  import psout_pkg::*;
#(
  parameter int unsigned CNT_W = 28,
  parameter int unsigned DELAY_CYC [8] = '{default: 4}
) (
  // Clock, reset and inputs
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire psout_sense_t sense,
  input wire logic watchdog_out_active,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // Outputs
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire psout_pin_t reset_out_pin,
  input wire psout_pin_t supply_fault_out_pin
);
  logic [3:0][7:0] sh_r;
  logic [31:0] mr_hi_r;
  wire logic wr_hit = clk_en && reg_wr_en && reg_addr >= 8'h11 && reg_addr <= 8'h14;
  wire logic [7:0] rc = sh_r[0];
  wire logic [7:0] rg = sh_r[1];
  wire logic [7:0] fc = sh_r[2];
  // Shadow registers, and cycles since manual reset was last low
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sh_r <= {8'h00, 8'h02, 8'h00, 8'h01};
      mr_hi_r <= 32'h0;
    end else begin
      if (wr_hit) begin
        sh_r[reg_addr[1:0] - 2'h1] <= reg_wdata;
      end
      mr_hi_r <= sense.manual_reset_in_b ? mr_hi_r + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_pin_never_high:
    assert property (!reset_out_pin.out && !supply_fault_out_pin.out) else $error("pin high");
  a_lockout_low:
    assert property ((!sense.supply_ok) [*5] |-> reset_out_pin.oe && supply_fault_out_pin.oe)
    else $error("lockout not asserting");
  a_none_sel_low:
    assert property ((rc == 8'h00 && !rg[7] && sense.test_hold_b) [*6] |-> reset_out_pin.oe)
    else $error("unconfigured reset released");
  a_mr_asserts_rst:
    assert property ((rc[0] && !sense.manual_reset_in_b && sense.test_hold_b) [*7]
      |-> reset_out_pin.oe) else $error("manual reset ignored");
  a_wdo_asserts_rst:
    assert property ((rg[7] && watchdog_out_active && sense.test_hold_b) [*6]
      |-> reset_out_pin.oe) else $error("watchdog ignored");
  a_rst_release_dly:
    assert property ($fell(reset_out_pin.oe) && rc == 8'h01 && !rg[7]
      |-> mr_hi_r > DELAY_CYC[rg[3:1]]) else $error("reset released early");
  a_flt_release_dly:
    assert property ($fell(supply_fault_out_pin.oe) && fc == 8'h01
      |-> mr_hi_r > DELAY_CYC[sh_r[3][3:1]]) else $error("fault released early");
  a_rst_pull_type:
    assert property ((!reset_out_pin.oe && $stable(rg[0])) [*3]
      |-> reset_out_pin.pull_en == !rg[0]) else $error("reset driver type wrong");
  a_hold_freeze:
    assert property ((!sense.test_hold_b && sense.supply_ok) [*6]
      |-> $stable(reset_out_pin.oe) && $stable(supply_fault_out_pin.oe))
    else $error("output moved during hold");
  c_rst_released: cover property ($fell(reset_out_pin.oe));
  c_flt_released: cover property ($fell(supply_fault_out_pin.oe));
  c_hold_low: cover property (!sense.test_hold_b && reset_out_pin.oe);
endmodule
bind psout_top psout_chk #(.CNT_W(CNT_W), .DELAY_CYC(DELAY_CYC)) psout_chk_i (
  .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .sense(sense),
  .watchdog_out_active(watchdog_out_active), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .reset_out_pin(reset_out_pin), .supply_fault_out_pin(supply_fault_out_pin));
`default_nettype wire

// file: verif/psout_far_model.sv
// Board side of the two supervisor lines, as the processor sees them.
// Assumes no external pull-up unless EXT_PULLUP is set.
`timescale 1ns/1ps
`default_nettype none
module psout_far_model
  import psout_pkg::*;
#(
  parameter bit EXT_PULLUP = 1'b0
) (
  // Device side
  input wire logic clk_sys,
  input wire psout_pin_t reset_out_pin,
  input wire psout_pin_t supply_fault_out_pin,
  // Line levels
  output logic rst_line_b,
  output logic flt_line_b
);
  logic drift_r = 1'b0;
  // An undriven line with no pull-up wanders rather than parking
  always @(posedge clk_sys) drift_r <= !drift_r;
  wire logic idle_lvl = EXT_PULLUP | drift_r;
  assign rst_line_b = !reset_out_pin.oe && (reset_out_pin.pull_en || idle_lvl);
  assign flt_line_b = !supply_fault_out_pin.oe && (supply_fault_out_pin.pull_en || idle_lvl);
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for psout_top with shortened release delays.
// Assumes the far-side model resolves the output lines.
`timescale 1ns/1ps
`default_nettype none
module tb_top import psout_pkg::*;;
  localparam int unsigned DLY [8] = '{4, 6, 8, 10, 12, 14, 16, 18};
  logic clk_sys, rst_b, reg_wr_en, reg_rd_en, reg_rvalid, watchdog_out, rst_line_b, flt_line_b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [5:0] bm;
  psout_sense_t sense;
  psout_pin_t rst_pin, flt_pin;
  int fails = 0;
  int checked = 0;
  int n, b0, b1;
  wire logic [1:0] oe = {rst_pin.oe, flt_pin.oe};
  psout_top #(.DELAY_CYC(DLY)) psout_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1),
    .sense(sense), .watchdog_out_active(watchdog_out), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reset_out_pin(rst_pin), .supply_fault_out_pin(flt_pin));
  psout_far_model psout_far_model_i (.clk_sys(clk_sys), .reset_out_pin(rst_pin),
    .supply_fault_out_pin(flt_pin), .rst_line_b(rst_line_b), .flt_line_b(flt_line_b));
  task automatic final_report();
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    cmp({7'h00, reg_rvalid}, 8'h00);
    {reg_rd_en, reg_addr} = {1'b1, a};
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    cmp(reg_rdata, exp);
    cmp({7'h00, reg_rvalid}, 8'h01);
  endtask
  // Stimulus word: watchdog, then the sense struct
  task automatic sv(input logic [15:0] v);
    @(negedge clk_sys);
    {watchdog_out, sense} = v;
  endtask
  task automatic wt(input logic [1:0] m, input logic [1:0] v, output int c);
    for (c = 0; c < 60 && (oe & m) !== v; c++) @(negedge clk_sys);
  endtask
  task automatic ex(input logic [1:0] m, input logic [1:0] v);
    wt(m, v, n);
    cmp({6'h00, oe & m}, {6'h00, v});
  endtask
  task automatic st(input logic [1:0] v);
    repeat (30) @(negedge clk_sys);
    cmp({6'h00, oe}, {6'h00, v});
  endtask
  // Cycles from manual reset rising to release of the masked output
  task automatic meas(input logic [1:0] m, output int c);
    sv(16'h3000);
    repeat (8) @(negedge clk_sys);
    ex(m, m);
    sv(16'h7000);
    wt(m, 2'h0, c);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = !clk_sys;
  end
  initial begin
    #100000;
    fails++;
    final_report();
  end
  initial begin
    {rst_b, reg_wr_en, reg_rd_en, reg_addr, reg_wdata, watchdog_out} = '0;
    sense = 15'h7000;
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    rd(8'h11, 8'h01);
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h02);
    rd(8'h14, 8'h00);
    rd(8'h20, 8'h00);
    ex(2'h3, 2'h0);
    cmp({6'h00, rst_line_b, flt_line_b}, 8'h03);
    cmp({6'h00, rst_pin.out, flt_pin.out}, 8'h00);
    wr(8'h12, 8'hff);
    rd(8'h12, 8'h8f);
    wr(8'h14, 8'hff);
    rd(8'h14, 8'h0f);
    repeat (3) @(negedge clk_sys);
    cmp({6'h00, rst_pin.pull_en, flt_pin.pull_en}, 8'h00);
    wr(8'h12, 8'h00);
    wr(8'h14, 8'h00);
    repeat (2) @(negedge clk_sys);
    cmp({6'h00, rst_pin.pull_en, flt_pin.pull_en}, 8'h03);
    for (int i = 0; i < 6; i++) begin
      wr(8'h11, 8'h04 << i);
      sv({4'h7, ~(6'h01 << i), 6'h00});
      st(2'h0);
      sv(16'h7fc0);
      ex(2'h2, 2'h2);
      sv(16'h7000);
      ex(2'h3, 2'h0);
    end
    wr(8'h11, 8'h01);
    meas(2'h1, n);
    wr(8'h11, 8'h02);
    wr(8'h13, 8'h01);
    meas(2'h2, n);
    wr(8'h11, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(8'h12, 8'(c << 1));
      wr(8'h14, 8'(c << 1));
      meas(2'h2, n);
      b0 = (c == 0) ? n : b0;
      cmp(8'(n - b0), 8'(DLY[c] - DLY[0]));
      meas(2'h1, n);
      b1 = (c == 0) ? n : b1;
      cmp(8'(n - b1), 8'(DLY[c] - DLY[0]));
    end
    for (int i = 0; i < 6; i++) begin
      bm = 6'h01 << i;
      wr(8'h13, 8'h04 << i);
      for (int m = 0; m < 2; m++) begin
        wr(8'h0e, 8'(m << i));
        sv({10'h1c0, m ? 6'h00 : bm});
        ex(2'h1, 2'h1);
        sv({10'h1c0, m ? bm : 6'h00});
        ex(2'h1, 2'h0);
      end
    end
    wr(8'h0e, 8'hff);
    rd(8'h0e, 8'h3f);
    wr(8'h13, 8'h01);
    wr(8'h12, 8'h80);
    sv(16'hf000);
    ex(2'h2, 2'h2);
    st(2'h2);
    sv(16'h7000);
    ex(2'h2, 2'h0);
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    wr(8'h13, 8'h00);
    st(2'h3);
    wr(8'h11, 8'h01);
    wr(8'h13, 8'h01);
    ex(2'h3, 2'h0);
    sv(16'h4000);
    ex(2'h3, 2'h3);
    rd(8'h30, 8'h0f);
    cmp({6'h00, rst_line_b, flt_line_b}, 8'h00);
    sv(16'h5000);
    st(2'h3);
    sv(16'h7000);
    ex(2'h3, 2'h0);
    sv(16'h5000);
    sv(16'h1000);
    st(2'h0);
    sv(16'h7000);
    final_report();
  end
endmodule
`default_nettype wire
